// ---- hw/stled_pkg.sv ----
// package: constants for the status and fault indicator block
package stled_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BOOT_TIME_MS = 2_000;
  localparam int unsigned SETTLE_TIME_MS = 10_000;
  localparam int unsigned SDO_MAX_MS = 150;
  localparam int unsigned BLINK_2HZ_HALF_MS = 250;
  localparam int unsigned BOOT_CYCLES = CLK_HZ / 1_000 * BOOT_TIME_MS;
  localparam int unsigned SETTLE_CYCLES = CLK_HZ / 1_000 * SETTLE_TIME_MS;
  localparam int unsigned SDO_MAX_CYCLES = CLK_HZ / 1_000 * SDO_MAX_MS;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / 1_000 * BLINK_2HZ_HALF_MS;

  // register map (word addresses on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_ERRCODE = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_CLR = 4'h4;
  localparam logic [3:0] REG_IRQ_EN = 4'h5;
  localparam logic [3:0] REG_COND = 4'h6;

  // condition bit positions
  localparam int unsigned COND_W = 8;
  localparam int unsigned C_OC_A = 0;
  localparam int unsigned C_OC_B = 1;
  localparam int unsigned C_OPEN_A = 2;
  localparam int unsigned C_OPEN_B = 3;
  localparam int unsigned C_AI_CMD = 4;
  localparam int unsigned C_EXT_SENS = 5;
  localparam int unsigned C_POS_SENS = 6;
  localparam int unsigned C_SUPPLY = 7;

  // interrupt event bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FAULT_SET = 0;
  localparam int unsigned IRQ_FAULT_CLR = 1;
  localparam int unsigned IRQ_WARN = 2;
  localparam int unsigned IRQ_SDO_LATE = 3;

  // error codes
  localparam logic [15:0] EC_NONE = 16'h0000;
  localparam logic [15:0] EC_COIL_A = 16'h5411;
  localparam logic [15:0] EC_COIL_B = 16'h5412;
  localparam logic [15:0] EC_AI_CMD = 16'h3420;
  localparam logic [15:0] EC_EXT_SENS = 16'h5230;
  localparam logic [15:0] EC_POS_SENS = 16'h7300;
  localparam logic [15:0] EC_SUPPLY = 16'h3410;

  // rgb bit order {red, green, blue}
  localparam logic [2:0] RGB_OFF = 3'h0;
  localparam logic [2:0] RGB_WHITE = 3'h7;
  localparam logic [2:0] RGB_GREEN = 3'h2;
  localparam logic [2:0] RGB_RED = 3'h4;
  localparam logic [2:0] RGB_BLUE = 3'h1;
  localparam logic [2:0] RGB_MAGENTA = 3'h5;

  // can bit rate select codes; code 7 (10 kbit/s) is refused
  localparam logic [2:0] RATE_1M = 3'h0;
  localparam logic [2:0] RATE_20K = 3'h6;
  localparam logic [2:0] RATE_10K = 3'h7;
  localparam logic [2:0] RATE_DEFAULT = 3'h2;

  typedef enum logic [2:0] {
    STLED_BOOT = 3'b001,
    STLED_RUN = 3'b010,
    STLED_FAULT = 3'b100
  } stled_mode_e;

endpackage

// ---- hw/stled_top.sv ----
// status and fault indicator controller for a proportional valve
`timescale 1ns/1ps

module stled_top #(
  parameter int unsigned BOOT_CYC = stled_pkg::BOOT_CYCLES,
  parameter int unsigned SETTLE_CYC = stled_pkg::SETTLE_CYCLES,
  parameter int unsigned SDO_CYC = stled_pkg::SDO_MAX_CYCLES,
  parameter int unsigned BLINK_CYC = stled_pkg::BLINK_HALF_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // condition inputs from the valve electronics
  input wire logic [stled_pkg::COND_W-1:0] fault_cond_in,
  input wire logic warn_in,
  input wire logic bus_operational_in,
  input wire logic sdo_req_in,
  input wire logic sdo_done_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // indicators and valve control
  output logic [2:0] power_indicator_out,
  output logic fault_indicator_out,
  output logic bus_indicator_out,
  output logic spool_neutral_out,
  output logic [2:0] can_rate_out,
  output logic sdo_timeout_out,
  output logic irq_out
);

  localparam int unsigned CW = 32;

  ////////////////////////////////////////////////////////////////////////
  // shared blink timebase

  logic [CW-1:0] blink_cnt;
  logic [CW-1:0] next_blink_cnt;
  logic blink_2hz;
  logic next_blink_2hz;
  logic blink_1hz;
  logic next_blink_1hz;

  // one counter feeds both rates so every lamp toggles in phase
  always_comb
  begin
    next_blink_cnt = blink_cnt + CW'(1);
    next_blink_2hz = blink_2hz;
    next_blink_1hz = blink_1hz;
    if (blink_cnt >= CW'(BLINK_CYC - 1))
    begin
      next_blink_cnt = '0;
      next_blink_2hz = ~blink_2hz;
      if (blink_2hz)
        next_blink_1hz = ~blink_1hz;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      blink_cnt <= '0;
      blink_2hz <= 1'b0;
      blink_1hz <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink_2hz <= next_blink_2hz;
      blink_1hz <= next_blink_1hz;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing: boot, run, fault with settle delay

  stled_pkg::stled_mode_e mode;
  stled_pkg::stled_mode_e next_mode;
  logic [CW-1:0] mode_cnt;
  logic [CW-1:0] next_mode_cnt;
  logic any_fault;

  assign any_fault = |fault_cond_in;

  always_comb
  begin
    next_mode = mode;
    next_mode_cnt = mode_cnt;
    unique case (mode)
      stled_pkg::STLED_BOOT:
      begin
        next_mode_cnt = mode_cnt + CW'(1);
        if (mode_cnt >= CW'(BOOT_CYC - 1))
        begin
          next_mode_cnt = '0;
          next_mode = any_fault ? stled_pkg::STLED_FAULT : stled_pkg::STLED_RUN;
        end
      end
      stled_pkg::STLED_RUN:
      begin
        next_mode_cnt = '0;
        if (any_fault)
          next_mode = stled_pkg::STLED_FAULT;
      end
      stled_pkg::STLED_FAULT:
      begin
        // settle count restarts whenever the fault reappears
        if (any_fault)
          next_mode_cnt = '0;
        else if (mode_cnt >= CW'(SETTLE_CYC - 1))
        begin
          next_mode_cnt = '0;
          next_mode = stled_pkg::STLED_RUN;
        end
        else
          next_mode_cnt = mode_cnt + CW'(1);
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode <= stled_pkg::STLED_BOOT;
      mode_cnt <= '0;
    end
    else
    begin
      mode <= next_mode;
      mode_cnt <= next_mode_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicator pattern and error code

  logic [2:0] next_power;
  logic next_fault_led;
  logic next_bus_led;
  logic next_neutral;
  logic [15:0] next_errcode;
  logic [15:0] errcode;
  logic [3:0] n_active;
  logic multi;

  always_comb
  begin
    n_active = {3'h0, warn_in};
    for (int i = 0; i < stled_pkg::COND_W; i++)
      n_active = n_active + {3'h0, fault_cond_in[i]};
  end

  assign multi = n_active > 4'h1;

  always_comb
  begin
    next_power = stled_pkg::RGB_GREEN;
    next_fault_led = 1'b0;
    next_errcode = stled_pkg::EC_NONE;
    next_bus_led = bus_operational_in;
    // neutral held while fault present or still settling
    next_neutral = (mode == stled_pkg::STLED_FAULT) || any_fault;
    if (mode == stled_pkg::STLED_BOOT)
    begin
      next_power = stled_pkg::RGB_WHITE;
      next_fault_led = 1'b1;
      next_bus_led = 1'b1;
      next_neutral = any_fault;
    end
    else if (fault_cond_in[stled_pkg::C_OC_A] || fault_cond_in[stled_pkg::C_OPEN_A])
    begin
      next_power = stled_pkg::RGB_BLUE;
      next_fault_led = fault_cond_in[stled_pkg::C_OC_A] ? blink_2hz : blink_1hz;
      next_errcode = stled_pkg::EC_COIL_A;
    end
    else if (fault_cond_in[stled_pkg::C_OC_B] || fault_cond_in[stled_pkg::C_OPEN_B])
    begin
      next_power = stled_pkg::RGB_MAGENTA;
      next_fault_led = fault_cond_in[stled_pkg::C_OC_B] ? blink_2hz : blink_1hz;
      next_errcode = stled_pkg::EC_COIL_B;
    end
    else if (fault_cond_in[stled_pkg::C_AI_CMD])
    begin
      next_power = blink_2hz ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF;
      next_fault_led = blink_1hz;
      next_errcode = stled_pkg::EC_AI_CMD;
    end
    else if (fault_cond_in[stled_pkg::C_EXT_SENS])
    begin
      next_power = blink_1hz ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF;
      next_fault_led = blink_1hz;
      next_errcode = stled_pkg::EC_EXT_SENS;
    end
    else if (fault_cond_in[stled_pkg::C_POS_SENS])
    begin
      next_power = blink_1hz ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF;
      next_fault_led = blink_1hz;
      next_errcode = stled_pkg::EC_POS_SENS;
    end
    else if (fault_cond_in[stled_pkg::C_SUPPLY])
    begin
      next_power = blink_2hz ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF;
      next_fault_led = 1'b1;
      next_errcode = stled_pkg::EC_SUPPLY;
    end
    // a lone warning changes nothing here; its pattern rows are not modelled
    // several conditions override the lamps only, so the leading fault keeps its code
    if (mode != stled_pkg::STLED_BOOT && multi)
    begin
      next_power = blink_2hz ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF;
      next_fault_led = any_fault & blink_2hz;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      power_indicator_out <= stled_pkg::RGB_WHITE;
      fault_indicator_out <= 1'b1;
      bus_indicator_out <= 1'b1;
      spool_neutral_out <= 1'b1;
      errcode <= stled_pkg::EC_NONE;
    end
    else
    begin
      power_indicator_out <= next_power;
      fault_indicator_out <= next_fault_led;
      bus_indicator_out <= next_bus_led;
      spool_neutral_out <= next_neutral;
      errcode <= next_errcode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sdo response watchdog

  logic sdo_busy;
  logic next_sdo_busy;
  logic [CW-1:0] sdo_cnt;
  logic [CW-1:0] next_sdo_cnt;
  logic next_sdo_to;
  logic sdo_late_evt;

  // late flag marks a breach of the answer bound to the firmware side
  always_comb
  begin
    next_sdo_busy = sdo_busy;
    next_sdo_cnt = sdo_cnt;
    next_sdo_to = sdo_timeout_out;
    sdo_late_evt = 1'b0;
    if (sdo_done_in)
    begin
      next_sdo_busy = 1'b0;
      next_sdo_to = 1'b0;
    end
    else if (sdo_req_in)
    begin
      next_sdo_busy = 1'b1;
      next_sdo_cnt = '0;
      next_sdo_to = 1'b0;
    end
    else if (sdo_busy)
    begin
      next_sdo_cnt = sdo_cnt + CW'(1);
      if (sdo_cnt == CW'(SDO_CYC - 1))
      begin
        next_sdo_to = 1'b1;
        sdo_late_evt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sdo_busy <= 1'b0;
      sdo_cnt <= '0;
      sdo_timeout_out <= 1'b0;
    end
    else
    begin
      sdo_busy <= next_sdo_busy;
      sdo_cnt <= next_sdo_cnt;
      sdo_timeout_out <= next_sdo_to;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and interrupts

  logic [2:0] next_rate;
  logic [stled_pkg::IRQ_W-1:0] irq_stat;
  logic [stled_pkg::IRQ_W-1:0] next_irq_stat;
  logic [stled_pkg::IRQ_W-1:0] irq_en;
  logic [stled_pkg::IRQ_W-1:0] next_irq_en;
  logic [stled_pkg::IRQ_W-1:0] irq_evt;
  logic [31:0] next_rdata;
  logic prev_fault_mode;
  logic prev_warn;
  logic next_irq;

  assign irq_evt[stled_pkg::IRQ_FAULT_SET] = (mode == stled_pkg::STLED_FAULT) & ~prev_fault_mode;
  assign irq_evt[stled_pkg::IRQ_FAULT_CLR] = (mode != stled_pkg::STLED_FAULT) & prev_fault_mode;
  assign irq_evt[stled_pkg::IRQ_WARN] = warn_in & ~prev_warn;
  assign irq_evt[stled_pkg::IRQ_SDO_LATE] = sdo_late_evt;

  always_comb
  begin
    next_rate = can_rate_out;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (reg_wr_in && reg_addr_in == stled_pkg::REG_CTRL && reg_wdata_in[2:0] != stled_pkg::RATE_10K)
      next_rate = reg_wdata_in[2:0];
    if (reg_wr_in && reg_addr_in == stled_pkg::REG_IRQ_EN)
      next_irq_en = reg_wdata_in[stled_pkg::IRQ_W-1:0];
    if (reg_wr_in && reg_addr_in == stled_pkg::REG_IRQ_CLR)
      next_irq_stat = irq_stat & ~reg_wdata_in[stled_pkg::IRQ_W-1:0];
    // set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | irq_evt;
    next_irq = |(next_irq_stat & next_irq_en);
    next_rdata = '0;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        stled_pkg::REG_CTRL: next_rdata = {29'h0, can_rate_out};
        stled_pkg::REG_STATUS: next_rdata = {24'h0, sdo_timeout_out, spool_neutral_out, bus_operational_in,
                                             warn_in, 1'b0, mode};
        stled_pkg::REG_ERRCODE: next_rdata = {16'h0, errcode};
        stled_pkg::REG_IRQ_STAT: next_rdata = {28'h0, irq_stat};
        stled_pkg::REG_IRQ_EN: next_rdata = {28'h0, irq_en};
        stled_pkg::REG_COND: next_rdata = {24'h0, fault_cond_in};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      can_rate_out <= stled_pkg::RATE_DEFAULT;
      irq_en <= '0;
      irq_stat <= '0;
      reg_rdata_out <= '0;
      irq_out <= 1'b0;
      prev_fault_mode <= 1'b0;
      prev_warn <= 1'b0;
    end
    else
    begin
      can_rate_out <= next_rate;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      reg_rdata_out <= next_rdata;
      irq_out <= next_irq;
      prev_fault_mode <= (mode == stled_pkg::STLED_FAULT);
      prev_warn <= warn_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence fault_seen;
    any_fault && mode != stled_pkg::STLED_BOOT;
  endsequence

  chk_fault_neutral: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    fault_seen |=> spool_neutral_out) else $error("spool not neutral on fault");
  chk_settle_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $fell(any_fault) && mode == stled_pkg::STLED_FAULT |=> mode == stled_pkg::STLED_FAULT)
    else $error("left fault mode before settle");
  chk_warn_run: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode == stled_pkg::STLED_RUN && !any_fault |=> !spool_neutral_out) else $error("warning stopped control");
  chk_boot_white: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode == stled_pkg::STLED_BOOT |=> power_indicator_out == stled_pkg::RGB_WHITE && fault_indicator_out)
    else $error("boot pattern wrong");
  chk_run_green: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode == stled_pkg::STLED_RUN && n_active == 4'h0 |=> power_indicator_out == stled_pkg::RGB_GREEN
    && !fault_indicator_out) else $error("normal pattern wrong");
  chk_bus_follow: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode != stled_pkg::STLED_BOOT |=> bus_indicator_out == $past(bus_operational_in))
    else $error("bus lamp not normal");
  chk_supply_code: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode != stled_pkg::STLED_BOOT && fault_cond_in == 8'h80 && !warn_in |=> errcode == stled_pkg::EC_SUPPLY
    && fault_indicator_out) else $error("supply fault code wrong");
  chk_rate_refuse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ##1 can_rate_out != stled_pkg::RATE_10K) else $error("unsupported rate taken");
  // one warning bit only, so several conditions always include a fault here
  chk_multi_red: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mode != stled_pkg::STLED_BOOT && multi |=> fault_indicator_out == $past(blink_2hz)
    && power_indicator_out == ($past(blink_2hz) ? stled_pkg::RGB_RED : stled_pkg::RGB_OFF))
    else $error("several conditions pattern wrong");

endmodule

// ---- tb/stled_sdo_master.sv ----
// behavioural fieldbus master: issues sdo requests, answers after a chosen delay
`timescale 1ns/1ps

module stled_sdo_master (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // control from the bench
  input wire logic start_in,
  input wire logic [7:0] delay_in,
  // request and answer pulses towards the block
  output logic sdo_req_out,
  output logic sdo_done_out
);
  logic [7:0] cnt;
  logic busy;

  // whole 2.0b frames are abstracted to one pulse each way
  // one request in flight at a time, as a real client waits for its answer
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sdo_req_out <= 1'b0;
      sdo_done_out <= 1'b0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      sdo_req_out <= start_in && !busy;
      sdo_done_out <= busy && cnt == 8'h01;
      if (start_in && !busy)
      begin
        busy <= 1'b1;
        cnt <= delay_in;
      end
      else if (busy)
      begin
        cnt <= cnt - 8'h01;
        busy <= cnt != 8'h01;
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the status and fault indicator block
`timescale 1ns/1ps

module testbench;
  localparam int BOOT = 20;
  localparam int SETTLE = 50;
  localparam int SDO = 30;
  localparam int B = 4;
  typedef struct {
    logic [7:0] cond;
    logic w;
    logic [2:0] color;
    int pwr_half;
    int flt_half;
    logic [15:0] code;
  } stled_row_s;
  stled_row_s rows[10];
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] cond = 8'h00;
  logic warn = 1'b0;
  logic bus_op = 1'b0;
  logic sdo_go = 1'b0;
  logic [7:0] sdo_dly = 8'h05;
  logic sdo_req, sdo_done;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, rv;
  logic [2:0] pwr, rate;
  logic flt, busl, neutral, sdo_to, irq;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end

  stled_top #(.BOOT_CYC(BOOT), .SETTLE_CYC(SETTLE), .SDO_CYC(SDO), .BLINK_CYC(B)) uut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .fault_cond_in(cond), .warn_in(warn),
    .bus_operational_in(bus_op), .sdo_req_in(sdo_req), .sdo_done_in(sdo_done),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .power_indicator_out(pwr), .fault_indicator_out(flt),
    .bus_indicator_out(busl), .spool_neutral_out(neutral), .can_rate_out(rate),
    .sdo_timeout_out(sdo_to), .irq_out(irq));

  stled_sdo_master model (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .start_in(sdo_go),
    .delay_in(sdo_dly), .sdo_req_out(sdo_req), .sdo_done_out(sdo_done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic pick(input int sel);
    return sel ? flt : pwr[2];
  endfunction

  // first pass finds an edge, second counts one full half period
  task automatic half(input int sel, output int cnt);
    logic v;
    for (int i = 0; i < 2; i++)
    begin
      v = pick(sel);
      cnt = 0;
      while (pick(sel) === v && cnt < 40)
      begin
        @(posedge mclk_in);
        #1;
        cnt++;
      end
    end
  endtask

  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = '{8'h01, 1'b0, 3'h1, 0, B, 16'h5411};
    rows[1] = '{8'h02, 1'b0, 3'h5, 0, B, 16'h5412};
    rows[2] = '{8'h04, 1'b0, 3'h1, 0, 2 * B, 16'h5411};
    rows[3] = '{8'h08, 1'b0, 3'h5, 0, 2 * B, 16'h5412};
    rows[4] = '{8'h10, 1'b0, 3'h4, B, 2 * B, 16'h3420};
    rows[5] = '{8'h20, 1'b0, 3'h4, 2 * B, 2 * B, 16'h5230};
    rows[6] = '{8'h40, 1'b0, 3'h4, 2 * B, 2 * B, 16'h7300};
    rows[7] = '{8'h80, 1'b0, 3'h4, B, 0, 16'h3410};
    rows[8] = '{8'h81, 1'b0, 3'h4, B, B, 16'h5411};
    rows[9] = '{8'h20, 1'b1, 3'h4, B, B, 16'h5230};
    wait_cyc(8);
    check({pwr, flt, busl, neutral, rate}, {3'h7, 3'h7, 3'h2});
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    wait_cyc(BOOT - 4);
    check({pwr, flt, busl}, {3'h7, 2'h3});
    wait_cyc(8);
    check({pwr, flt, busl, neutral}, {3'h2, 3'h0});
    @(posedge mclk_in);
    bus_op <= 1'b1;
    wait_cyc(3);
    check({pwr, flt, busl}, {3'h2, 2'h1});
    reg_rd(stled_pkg::REG_ERRCODE, rv);
    check(rv, 32'h0000_0000);
    @(posedge mclk_in);
    warn <= 1'b1;
    wait_cyc(3);
    check({neutral, pwr}, {1'b0, 3'h2});
    reg_wr(stled_pkg::REG_IRQ_EN, 32'h0000_000f);
    foreach (rows[i])
    begin
      @(posedge mclk_in);
      cond <= rows[i].cond;
      warn <= rows[i].w;
      wait_cyc(3);
      check({neutral, busl}, 2'h3);
      reg_rd(stled_pkg::REG_ERRCODE, rv);
      check(rv, {16'h0000, rows[i].code});
      reg_rd(stled_pkg::REG_COND, rv);
      check(rv, {24'h00_0000, rows[i].cond});
      if (rows[i].pwr_half == 0)
        check(pwr, rows[i].color);
      else
      begin
        half(0, n);
        check(n, rows[i].pwr_half);
        check(pwr[1:0], 2'h0);
      end
      if (rows[i].flt_half == 0)
        check(flt, 1'b1);
      else
      begin
        half(1, n);
        check(n, rows[i].flt_half);
      end
      @(posedge mclk_in);
      cond <= 8'h00;
      warn <= 1'b0;
      wait_cyc(SETTLE - 8);
      reg_rd(stled_pkg::REG_STATUS, rv);
      check({rv[2:0], neutral}, {3'h4, 1'b1});
      wait_cyc(12);
      check({pwr, flt, busl, neutral}, {3'h2, 3'h2});
    end
    // interrupt: sticky status, write-one clear, masking
    check(irq, 1'b1);
    reg_rd(stled_pkg::REG_IRQ_STAT, rv);
    check(rv, 32'h0000_0007);
    reg_wr(stled_pkg::REG_IRQ_CLR, 32'h0000_0007);
    reg_wr(stled_pkg::REG_IRQ_EN, 32'h0000_0000);
    cond <= 8'h10;
    wait_cyc(4);
    check(irq, 1'b0);
    reg_rd(stled_pkg::REG_IRQ_STAT, rv);
    check(rv, 32'h0000_0001);
    reg_wr(stled_pkg::REG_IRQ_EN, 32'h0000_0001);
    wait_cyc(2);
    check(irq, 1'b1);
    // a fault returning during the settle time restarts it
    @(posedge mclk_in);
    cond <= 8'h00;
    wait_cyc(SETTLE / 2);
    @(posedge mclk_in);
    cond <= 8'h40;
    @(posedge mclk_in);
    cond <= 8'h00;
    wait_cyc(SETTLE - 8);
    reg_rd(stled_pkg::REG_STATUS, rv);
    check(rv[2:0], 3'h4);
    wait_cyc(12);
    check(neutral, 1'b0);
    // refused accesses and rate select
    reg_rd(4'hf, rv);
    check(rv, 32'h0000_0000);
    reg_wr(stled_pkg::REG_ERRCODE, 32'h0000_ffff);
    reg_rd(stled_pkg::REG_ERRCODE, rv);
    check(rv, 32'h0000_0000);
    reg_wr(stled_pkg::REG_CTRL, 32'h0000_0006);
    reg_wr(stled_pkg::REG_CTRL, 32'h0000_0007);
    reg_rd(stled_pkg::REG_CTRL, rv);
    check(rv, 32'h0000_0006);
    check(rate, 3'h6);
    // prompt then late answer from the master
    @(posedge mclk_in);
    sdo_go <= 1'b1;
    @(posedge mclk_in);
    sdo_go <= 1'b0;
    wait_cyc(SDO + 10);
    check(sdo_to, 1'b0);
    @(posedge mclk_in);
    sdo_dly <= 8'h28;
    sdo_go <= 1'b1;
    @(posedge mclk_in);
    sdo_go <= 1'b0;
    wait_cyc(SDO + 5);
    check(sdo_to, 1'b1);
    reg_rd(stled_pkg::REG_IRQ_STAT, rv);
    check(rv[3], 1'b1);
    wait_cyc(10);
    check(sdo_to, 1'b0);
    // reset in mid-run brings back the boot pattern and the default rate
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    wait_cyc(2);
    check({pwr, flt, busl, neutral, rate}, {3'h7, 3'h7, 3'h2});
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    wait_cyc(BOOT + 2);
    check({pwr, flt, busl, neutral}, {3'h2, 3'h2});
    stop_test();
  end
endmodule
